// File: csrx_byte_cdc.sv
// Link-clock byte capture after the leader byte, and toggle crossing to clk.
// Assumes one byte per link cycle and a link clock at most a third of clk.
`timescale 1ns/1ps
module csrx_byte_cdc (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic hs_en,
  input wire logic [7:0] hs_byte,
  output logic [7:0] byte_out,
  output logic byte_stb
);

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic locked;
    logic tog;
    logic [7:0] data;
  } csrx_link_state_t;

  typedef struct packed {
    logic t_s1;
    logic t_s2;
    logic t_s3;
    logic stb;
    logic [7:0] data;
  } csrx_sys_state_t;

  csrx_link_state_t l_ff;
  csrx_link_state_t nxt_l;
  csrx_sys_state_t s_ff;
  csrx_sys_state_t nxt_s;

  assign byte_out = s_ff.data;
  assign byte_stb = s_ff.stb;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain
  always_comb begin
    nxt_l = l_ff;
    nxt_l.en_s1 = hs_en;
    nxt_l.en_s2 = l_ff.en_s1;
    if (!l_ff.en_s2) begin
      nxt_l.locked = 1'b0;
    end else if (!l_ff.locked) begin
      nxt_l.locked = (hs_byte == csrx_pkg::SYNC_BYTE);
    end else begin
      nxt_l.data = hs_byte;
      nxt_l.tog = ~l_ff.tog;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      l_ff <= '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    end else begin
      l_ff <= nxt_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fabric domain; link data is held a full link period, so it is stable here
  always_comb begin
    nxt_s = s_ff;
    nxt_s.t_s1 = l_ff.tog;
    nxt_s.t_s2 = s_ff.t_s1;
    nxt_s.t_s3 = s_ff.t_s2;
    nxt_s.stb = s_ff.t_s2 ^ s_ff.t_s3;
    if (s_ff.t_s2 ^ s_ff.t_s3) nxt_s.data = l_ff.data;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule : csrx_byte_cdc

// File: csrx_lane_fsm.sv
// One D-PHY lane: low-power state tracking, settle timer, high-speed flag.
// Assumes lp_dp/lp_dn are raw pin levels; settle_cyc is quasi-static.
`timescale 1ns/1ps
module csrx_lane_fsm (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lp_dp,
  input wire logic lp_dn,
  input wire logic [6:0] settle_cyc,
  input wire logic hs_allow,
  output logic lane_hs
);

  typedef struct packed {
    logic [1:0] lp_s1;
    logic [1:0] lp_s2;
    csrx_pkg::csrx_lane_st_t st;
    logic [6:0] cnt;
    logic hs;
  } csrx_lane_state_t;

  csrx_lane_state_t s_ff;
  csrx_lane_state_t nxt_s;
  logic [6:0] eff;
  logic [1:0] lp;

  assign lp = s_ff.lp_s2;
  assign lane_hs = s_ff.hs;

  always_comb begin
    nxt_s = s_ff;
    // Out-of-range settings are pulled into the supported window
    if (settle_cyc < csrx_pkg::SETTLE_MIN_CYC) begin // R16
      eff = csrx_pkg::SETTLE_MIN_CYC;
    end else if (settle_cyc > csrx_pkg::SETTLE_MAX_CYC) begin
      eff = csrx_pkg::SETTLE_MAX_CYC;
    end else begin
      eff = settle_cyc;
    end
    nxt_s.lp_s1 = {lp_dp, lp_dn};
    nxt_s.lp_s2 = s_ff.lp_s1;
    case (s_ff.st)
      csrx_pkg::LANE_IDLE: begin
        if (lp == csrx_pkg::LP11) nxt_s.st = csrx_pkg::LANE_STOP;
      end
      csrx_pkg::LANE_STOP: begin
        if (lp == csrx_pkg::LP01) nxt_s.st = csrx_pkg::LANE_REQ; // R2
        else if (lp != csrx_pkg::LP11) nxt_s.st = csrx_pkg::LANE_IDLE;
      end
      csrx_pkg::LANE_REQ: begin
        if (lp == csrx_pkg::LP00) begin // R2
          nxt_s.st = csrx_pkg::LANE_SETTLE;
          nxt_s.cnt = eff - 7'h01;
        end else if (lp == csrx_pkg::LP11) begin
          nxt_s.st = csrx_pkg::LANE_STOP;
        end else if (lp != csrx_pkg::LP01) begin
          nxt_s.st = csrx_pkg::LANE_IDLE;
        end
      end
      csrx_pkg::LANE_SETTLE: begin
        // Line activity ends the window at once: LP-11 returns to stop, any other non-LP-00 level to idle
        if (lp == csrx_pkg::LP11) nxt_s.st = csrx_pkg::LANE_STOP;
        else if (lp != csrx_pkg::LP00) nxt_s.st = csrx_pkg::LANE_IDLE;
        else if (s_ff.cnt != 7'h00) nxt_s.cnt = s_ff.cnt - 7'h01; // R7 R11
        else if (hs_allow) nxt_s.st = csrx_pkg::LANE_HS; // R5
      end
      csrx_pkg::LANE_HS: begin
        if (lp == csrx_pkg::LP11) nxt_s.st = csrx_pkg::LANE_STOP; // R3
      end
      default: nxt_s.st = csrx_pkg::LANE_IDLE;
    endcase
    nxt_s.hs = (nxt_s.st == csrx_pkg::LANE_HS);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '{2'h0, 2'h0, csrx_pkg::LANE_IDLE, 7'h00, 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [6:0] age_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age_ff <= 7'h00;
    end else if (s_ff.st == csrx_pkg::LANE_SETTLE) begin
      // Saturate so a long wait for the clock lane never wraps to zero
      age_ff <= (age_ff == 7'h7f) ? age_ff : age_ff + 7'h01;
    end else begin
      age_ff <= 7'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_settle_full_len: assert property ($rose(s_ff.hs) |-> $past(age_ff) >= eff - 7'h01) // R7 R11
    else $error("lane entered HS before settle window ran out");
  a_settle_no_early: assert property (
    (s_ff.st == csrx_pkg::LANE_SETTLE && age_ff < eff - 7'h01) |=> !s_ff.hs) // R11
    else $error("lane HS during settle window");
  a_stop_ends_hs: assert property (
    (s_ff.st == csrx_pkg::LANE_HS && lp == csrx_pkg::LP11) |=> (!s_ff.hs ##1 !s_ff.hs)) // R3
    else $error("stop state did not end burst");
  a_req_after_stop: assert property (
    (s_ff.st == csrx_pkg::LANE_REQ && $past(s_ff.st) != csrx_pkg::LANE_REQ)
    |-> $past(s_ff.st) == csrx_pkg::LANE_STOP) // R2
    else $error("request state not entered from stop");
  a_settle_range: assert property (eff >= csrx_pkg::SETTLE_MIN_CYC
    && eff <= csrx_pkg::SETTLE_MAX_CYC) // R16
    else $error("settle count out of range");

endmodule : csrx_lane_fsm

// File: csrx_pixel_rx.sv
// CSI-2 receive pixel block: lane entry and exit, settle timing, pixel packing.
// Assumes raw LP pin levels, a link byte clock with deserialised bytes, and a
// data-type code supplied by fabric logic on clk.
//
// Summary of operation
// R1: Data type changes only while hsync low
// R2: HS entry needs LP-11, LP-01, LP-00 order
// R3: LP-11 on lane ends the burst
// R4: Transmitter clock post time 60ns+52UI minimum
// R5: Clock runs 8 UI before data HS
// R6: Clock prepare LP-00 lasts 38 to 95 ns
// R7: Clock settle window 95 to 300 ns
// R8: Clock trail HS-0 at least 60 ns
// R9: Clock prepare plus zero at least 300 ns
// R10: Data prepare 40ns+4UI to 85ns+6UI
// R11: Data settle ignores then responds by window
// R12: Data trail max(n*8UI, 60ns+n*4UI)
// R13: Every LP state lasts 50 ns minimum
// R14: Data prepare plus zero 145ns+10UI minimum
// R15: Code 0x1D: 40 bits, 4/2 pixels
// R16: Settle timers configurable 40 to 2590 ns
// R17: Fixed pixel count and width per type; code varies the non-legacy 4:2:0 8- and 10-bit pixel counts with line parity
// R18: Unknown types act as RAW8, flagged invalid
`timescale 1ns/1ps
module csrx_pixel_rx (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic clk_lane_dp,
  input wire logic clk_lane_dn,
  input wire logic data_lane_dp,
  input wire logic data_lane_dn,
  input wire logic [7:0] hs_byte,
  input wire logic [6:0] clock_lane_settle_window,
  input wire logic [6:0] data_lane_settle_window,
  input wire logic [5:0] data_type_in,
  output logic [63:0] pixel_data,
  output logic pixel_valid,
  output logic [3:0] pixel_count,
  output logic [4:0] pixel_bits,
  output logic hsync,
  output logic [5:0] data_type,
  output logic data_type_invalid,
  output logic line_odd,
  output logic line_overflow,
  output logic clock_lane_hs
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-type packing table
  function automatic csrx_pkg::csrx_fmt_t csrx_fmt(input logic [5:0] code, input logic odd);
    csrx_pkg::csrx_fmt_t f;
    f = {1'b1, 7'h40, 4'h8, 5'h08, 13'h1680};
    case (code)
      csrx_pkg::DT_RGB444: f = {1'b1, 7'h30, 4'h4, 5'h0c, 13'h0b40};
      csrx_pkg::DT_RGB555: f = {1'b1, 7'h3c, 4'h4, 5'h0f, 13'h0b40};
      csrx_pkg::DT_RGB565: f = {1'b1, 7'h40, 4'h4, 5'h10, 13'h0b40};
      csrx_pkg::DT_RGB666: f = {1'b1, 7'h36, 4'h3, 5'h12, 13'h09fc};
      csrx_pkg::DT_RGB888: f = {1'b1, 7'h30, 4'h2, 5'h18, 13'h0780};
      csrx_pkg::DT_RAW6: f = {1'b1, 7'h30, 4'h8, 5'h06, 13'h1e00};
      csrx_pkg::DT_RAW7: f = {1'b1, 7'h38, 4'h8, 5'h07, 13'h19b0};
      csrx_pkg::DT_RAW8: f = {1'b1, 7'h40, 4'h8, 5'h08, 13'h1680};
      csrx_pkg::DT_RAW10: f = {1'b1, 7'h28, 4'h4, 5'h0a, 13'h1200};
      csrx_pkg::DT_RAW12: f = {1'b1, 7'h30, 4'h4, 5'h0c, 13'h0f00};
      csrx_pkg::DT_RAW14: f = {1'b1, 7'h38, 4'h4, 5'h0e, 13'h0cd8};
      csrx_pkg::DT_YUV420_8, csrx_pkg::DT_YUV420_8_SHIFT: begin
        f = {1'b1, 7'h40, (odd ? 4'h8 : 4'h4), 5'h08, 13'h0b40};
      end
      csrx_pkg::DT_YUV420_10, csrx_pkg::DT_YUV420_10_SHIFT: begin
        f = {1'b1, 7'h28, (odd ? 4'h4 : 4'h2), 5'h0a, 13'h0900}; // R15
      end
      csrx_pkg::DT_YUV420_8_LEGACY: f = {1'b1, 7'h30, 4'h4, 5'h08, 13'h0f00};
      csrx_pkg::DT_YUV422_8: f = {1'b1, 7'h40, 4'h4, 5'h08, 13'h0b40};
      csrx_pkg::DT_YUV422_10: f = {1'b1, 7'h28, 4'h2, 5'h0a, 13'h0900};
      default: begin
        // User range is legal; anything else is packed the same but flagged
        f.ok = (code >= csrx_pkg::DT_USER_LO) && (code <= csrx_pkg::DT_USER_HI); // R18
      end
    endcase
    return f;
  endfunction : csrx_fmt

  ////////////////////////////////////////////////////////////////////////////
  // Lanes and byte crossing
  logic clk_hs_w;
  logic dat_hs_w;
  logic [7:0] byte_w;
  logic stb_w;

  csrx_lane_fsm u_clk_lane (
    .clk(clk),
    .arst_n(arst_n),
    .lp_dp(clk_lane_dp),
    .lp_dn(clk_lane_dn),
    .settle_cyc(clock_lane_settle_window),
    .hs_allow(1'b1),
    .lane_hs(clk_hs_w)
  );

  // Data lane may not go HS until the clock lane is already toggling
  csrx_lane_fsm u_data_lane (
    .clk(clk),
    .arst_n(arst_n),
    .lp_dp(data_lane_dp),
    .lp_dn(data_lane_dn),
    .settle_cyc(data_lane_settle_window),
    .hs_allow(clk_hs_w),
    .lane_hs(dat_hs_w)
  );

  csrx_byte_cdc u_cdc (
    .clk(clk),
    .arst_n(arst_n),
    .link_clk(link_clk),
    .hs_en(dat_hs_w),
    .hs_byte(hs_byte),
    .byte_out(byte_w),
    .byte_stb(stb_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pixel state
  typedef struct packed {
    logic [5:0] dtype;
    logic tinv;
    logic hsync;
    logic odd;
    logic [71:0] acc;
    logic [6:0] fill;
    logic [63:0] pix;
    logic pv;
    logic [3:0] pcnt;
    logic [4:0] pbits;
    logic [12:0] line_pix;
    logic ovf;
    logic clk_hs;
  } csrx_pix_state_t;

  csrx_pix_state_t s_ff;
  csrx_pix_state_t nxt_s;
  csrx_pkg::csrx_fmt_t fmt;

  assign pixel_data = s_ff.pix;
  assign pixel_valid = s_ff.pv;
  assign pixel_count = s_ff.pcnt;
  assign pixel_bits = s_ff.pbits;
  assign hsync = s_ff.hsync;
  assign data_type = s_ff.dtype;
  assign data_type_invalid = s_ff.tinv;
  assign line_odd = s_ff.odd;
  assign line_overflow = s_ff.ovf;
  assign clock_lane_hs = s_ff.clk_hs;

  always_comb begin
    logic [71:0] acc_t;
    logic [6:0] fill_t;
    acc_t = 72'h0;
    fill_t = 7'h00;
    nxt_s = s_ff;
    fmt = csrx_fmt(s_ff.dtype, s_ff.odd);
    nxt_s.clk_hs = clk_hs_w;
    nxt_s.hsync = dat_hs_w;
    nxt_s.pv = 1'b0;
    nxt_s.tinv = ~fmt.ok; // R18
    // Type is frozen for the whole line so the packing never shifts mid-line
    if (!s_ff.hsync) begin
      nxt_s.dtype = data_type_in; // R1
    end
    if (s_ff.hsync && !dat_hs_w) begin
      // Burst ended by stop state; a partial pixel group is dropped
      nxt_s.acc = 72'h0; // R3
      nxt_s.fill = 7'h00;
      nxt_s.odd = ~s_ff.odd;
      nxt_s.line_pix = 13'h0000;
      nxt_s.ovf = 1'b0;
    end else if (s_ff.hsync && stb_w) begin
      acc_t = s_ff.acc | ({64'h0, byte_w} << s_ff.fill);
      fill_t = s_ff.fill + 7'h08;
      if (fill_t >= fmt.bpc) begin
        nxt_s.pix = acc_t[63:0] & ~(64'hffff_ffff_ffff_ffff << fmt.bpc); // R17 R15
        nxt_s.acc = acc_t >> fmt.bpc;
        nxt_s.fill = fill_t - fmt.bpc;
        nxt_s.pv = 1'b1;
        nxt_s.pcnt = fmt.ppc; // R17
        nxt_s.pbits = fmt.bpp;
        if (!s_ff.ovf) begin
          nxt_s.line_pix = s_ff.line_pix + {9'h000, fmt.ppc};
          nxt_s.ovf = (s_ff.line_pix + {9'h000, fmt.ppc}) > fmt.max_pix;
        end
      end else begin
        nxt_s.acc = acc_t;
        nxt_s.fill = fill_t;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '{csrx_pkg::TYPE_RST, 1'b0, 1'b0, csrx_pkg::LINE_ODD_RST, 72'h0, 7'h00,
                64'h0, 1'b0, 4'h0, 5'h00, 13'h0000, 1'b0, 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_type_line_hold: assert property ((s_ff.hsync && $past(s_ff.hsync))
    |-> s_ff.dtype == $past(s_ff.dtype)) // R1
    else $error("data type changed during active line");
  a_shift10_count: assert property ((s_ff.pv && s_ff.dtype == csrx_pkg::DT_YUV420_10_SHIFT)
    |-> s_ff.pcnt == (s_ff.odd ? 4'h4 : 4'h2) && s_ff.pix[63:40] == 24'h0) // R15
    else $error("wrong pixel count for shifted 10-bit 4:2:0");
  a_raw8_eight: assert property ((s_ff.pv && s_ff.dtype == csrx_pkg::DT_RAW8)
    |-> $past(stb_w) && s_ff.pcnt == 4'h8 && s_ff.pbits == 5'h08) // R17
    else $error("raw 8-bit group not 8 pixels");
  a_rgb888_pairs: assert property ((s_ff.hsync && s_ff.dtype == csrx_pkg::DT_RGB888
    && stb_w && s_ff.fill == 7'h28) |=> s_ff.pv && s_ff.pcnt == 4'h2 && s_ff.fill == 7'h00) // R17
    else $error("24-bit RGB not emitted after six bytes");
  a_unknown_raw8: assert property ((s_ff.pv && s_ff.tinv) |-> s_ff.pcnt == 4'h8) // R18
    else $error("invalid type not packed as 8-bit");
  a_burst_flush: assert property ($fell(s_ff.hsync) |-> s_ff.fill == 7'h00
    && s_ff.odd != $past(s_ff.odd)) // R3
    else $error("burst end did not flush packer");
  a_data_needs_clk: assert property ($rose(dat_hs_w) |-> clk_hs_w) // R5
    else $error("data lane HS without clock lane HS");

  c_even_short_line: cover property (s_ff.pv && !s_ff.odd
    && s_ff.dtype == csrx_pkg::DT_YUV420_10_SHIFT);
  c_burst_end: cover property ($fell(s_ff.hsync) ##[1:20] $rose(s_ff.hsync));
  c_type_invalid: cover property (s_ff.pv && s_ff.tinv);
  c_line_overflow: cover property ($rose(s_ff.ovf));

endmodule : csrx_pixel_rx

// File: csrx_pixel_rx_test.sv
// Self-checking bench for the CSI-2 receive pixel block.
// Assumes the transmitter model owns every lane pin and the link clock.
`timescale 1ns/1ps
module csrx_pixel_rx_test;
  logic clk, arst_n, link_clk, cdp, cdn, ddp, ddn;
  logic [7:0] hs_byte;
  logic [6:0] cwin, dwin;
  logic [5:0] dt_in, data_type;
  logic [63:0] pixel_data;
  logic [3:0] pixel_count;
  logic [4:0] pixel_bits;
  logic pixel_valid, hsync, data_type_invalid, line_odd, line_overflow, clock_lane_hs;
  logic exp_odd, seen_hs, seen_chs;
  int fails, cmp_count;
  logic [63:0] got_d[$];
  logic [8:0] got_f[$];

  csrx_tx_model tx (.clk_dp(cdp), .clk_dn(cdn), .dat_dp(ddp), .dat_dn(ddn),
    .link_clk(link_clk), .hs_byte(hs_byte));
  csrx_pixel_rx dut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
    .clk_lane_dp(cdp), .clk_lane_dn(cdn), .data_lane_dp(ddp), .data_lane_dn(ddn),
    .hs_byte(hs_byte), .clock_lane_settle_window(cwin), .data_lane_settle_window(dwin),
    .data_type_in(dt_in), .pixel_data(pixel_data), .pixel_valid(pixel_valid),
    .pixel_count(pixel_count), .pixel_bits(pixel_bits), .hsync(hsync),
    .data_type(data_type), .data_type_invalid(data_type_invalid), .line_odd(line_odd),
    .line_overflow(line_overflow), .clock_lane_hs(clock_lane_hs));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Sample mid-cycle, away from the edge that launches the outputs
  always @(negedge clk) begin
    if (pixel_valid === 1'b1) begin
      got_d.push_back(pixel_data);
      got_f.push_back({pixel_count, pixel_bits});
    end
    if (hsync === 1'b1) seen_hs = 1'b1;
    if (clock_lane_hs === 1'b1) seen_chs = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait for hsync to reach a level
  task automatic wait_hsync(input logic lvl);
    int n;
    n = 0;
    while (hsync !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 200) begin
        fails++;
        $display("BAD hsync wait expected %b seen %b", lvl, hsync);
        close_out();
      end
    end
  endtask : wait_hsync

  // One burst of n bytes under type dt; bpc bits per group, ppc/bpp per group
  task automatic run_burst(input string name, input logic [5:0] dt, input int n,
      input int bpc, input logic [3:0] ppc, input logic [4:0] bpp, input logic inv);
    logic [7:0] b[$];
    logic [63:0] e;
    int k;
    for (int i = 0; i < n; i++) b.push_back(8'(i * 37 + 5));
    @(negedge clk);
    dt_in = dt;
    repeat (3) @(negedge clk);
    chk({name, " type"}, 64'(dt), 64'(data_type));
    chk({name, " parity"}, 64'(exp_odd), 64'(line_odd));
    got_d.delete();
    got_f.delete();
    seen_chs = 1'b0;
    fork
      tx.burst(b, 1'b1);
      begin
        wait_hsync(1'b1);
        @(negedge clk);
        dt_in = 6'h24;
        repeat (4) @(negedge clk);
        chk({name, " frozen type"}, 64'(dt), 64'(data_type));
        chk({name, " invalid"}, 64'(inv), 64'(data_type_invalid));
        chk({name, " overflow"}, 64'h0, 64'(line_overflow));
        wait_hsync(1'b0);
      end
    join
    exp_odd = ~exp_odd;
    chk({name, " clock hs"}, 64'h1, 64'(seen_chs));
    chk({name, " groups"}, 64'(n * 8 / bpc), 64'(got_d.size()));
    for (int g = 0; g < got_d.size() && g < n * 8 / bpc; g++) begin
      e = '0;
      for (int j = 0; j < bpc; j++) begin
        k = g * bpc + j;
        e[j] = b[k / 8][k % 8];
      end
      chk({name, " data"}, e, got_d[g]);
      chk({name, " format"}, 64'({ppc, bpp}), 64'(got_f[g]));
    end
    chk({name, " end parity"}, 64'(exp_odd), 64'(line_odd));
    $display("test %s done", name);
  endtask : run_burst

  // Data lane skips LP-01: no line may start and parity stays put
  task automatic bad_entry;
    logic [7:0] b[$];
    b = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h0f, 8'hf0, 8'h99, 8'h66};
    got_d.delete();
    seen_hs = 1'b0;
    tx.burst(b, 1'b0);
    repeat (5) @(negedge clk);
    chk("bad hsync", 64'h0, 64'(seen_hs));
    chk("bad groups", 64'h0, 64'(got_d.size()));
    chk("bad parity", 64'(exp_odd), 64'(line_odd));
    $display("test bad_entry done");
  endtask : bad_entry

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    cwin = 7'h05;
    dwin = 7'h04;
    dt_in = 6'h2a;
    fails = 0;
    cmp_count = 0;
    exp_odd = 1'b1;
    seen_hs = 1'b0;
    seen_chs = 1'b0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("reset type", 64'h2a, 64'(data_type));
    chk("reset parity", 64'h1, 64'(line_odd));
    chk("reset hsync", 64'h0, 64'({hsync, pixel_valid, clock_lane_hs}));
    run_burst("raw8", 6'h2a, 16, 64, 4'h8, 5'h08, 1'b0);
    run_burst("yuv10s even", 6'h1d, 5, 40, 4'h2, 5'h0a, 1'b0);
    run_burst("yuv10s odd", 6'h1d, 5, 40, 4'h4, 5'h0a, 1'b0);
    run_burst("raw10", 6'h2b, 10, 40, 4'h4, 5'h0a, 1'b0);
    run_burst("rgb888", 6'h24, 6, 48, 4'h2, 5'h18, 1'b0);
    run_burst("unknown", 6'h3f, 8, 64, 4'h8, 5'h08, 1'b1);
    run_burst("user", 6'h30, 8, 64, 4'h8, 5'h08, 1'b0);
    bad_entry();
    close_out();
  end
endmodule : csrx_pixel_rx_test

// File: csrx_pkg.sv
// Shared constants, state encodings and types for the CSI-2 receive pixel block.
// Assumes a 25 MHz fabric clock and a separate, slower link byte clock.
package csrx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETTLE_MIN_NS = 40;
  localparam int SETTLE_MAX_NS = 2590;
  // Least time rounds up, longest time rounds down
  localparam int SETTLE_MIN_CYC_I = (SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_MAX_CYC_I = SETTLE_MAX_NS / CLK_PERIOD_NS;
  localparam logic [6:0] SETTLE_MIN_CYC = 7'(SETTLE_MIN_CYC_I);
  localparam logic [6:0] SETTLE_MAX_CYC = 7'(SETTLE_MAX_CYC_I);

  ////////////////////////////////////////////////////////////////////////////
  // Low-power line states as {dp, dn}, and the high-speed leader byte
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;
  localparam logic [7:0] SYNC_BYTE = 8'hb8;

  ////////////////////////////////////////////////////////////////////////////
  // Video data-type codes
  localparam logic [5:0] DT_RGB444 = 6'h20;
  localparam logic [5:0] DT_RGB555 = 6'h21;
  localparam logic [5:0] DT_RGB565 = 6'h22;
  localparam logic [5:0] DT_RGB666 = 6'h23;
  localparam logic [5:0] DT_RGB888 = 6'h24;
  localparam logic [5:0] DT_RAW6 = 6'h28;
  localparam logic [5:0] DT_RAW7 = 6'h29;
  localparam logic [5:0] DT_RAW8 = 6'h2a;
  localparam logic [5:0] DT_RAW10 = 6'h2b;
  localparam logic [5:0] DT_RAW12 = 6'h2c;
  localparam logic [5:0] DT_RAW14 = 6'h2d;
  localparam logic [5:0] DT_YUV420_8 = 6'h18;
  localparam logic [5:0] DT_YUV420_10 = 6'h19;
  localparam logic [5:0] DT_YUV420_8_LEGACY = 6'h1a;
  localparam logic [5:0] DT_YUV420_8_SHIFT = 6'h1c;
  localparam logic [5:0] DT_YUV420_10_SHIFT = 6'h1d;
  localparam logic [5:0] DT_YUV422_8 = 6'h1e;
  localparam logic [5:0] DT_YUV422_10 = 6'h1f;
  localparam logic [5:0] DT_USER_LO = 6'h30;
  localparam logic [5:0] DT_USER_HI = 6'h37;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [5:0] TYPE_RST = DT_RAW8;
  localparam logic LINE_ODD_RST = 1'b1;

  typedef enum logic [2:0] {
    LANE_IDLE = 3'h0,
    LANE_STOP = 3'h1,
    LANE_REQ = 3'h3,
    LANE_SETTLE = 3'h2,
    LANE_HS = 3'h6
  } csrx_lane_st_t;

  typedef struct packed {
    logic ok;
    logic [6:0] bpc;
    logic [3:0] ppc;
    logic [4:0] bpp;
    logic [12:0] max_pix;
  } csrx_fmt_t;

endpackage : csrx_pkg

// File: csrx_tx_model.sv
// Camera transmitter model: both lanes' LP levels, the link clock and HS bytes.
// Assumes the receiver settles well inside the fixed HS-0 waits used below.
`timescale 1ns/1ps
module csrx_tx_model (
  output logic clk_dp,
  output logic clk_dn,
  output logic dat_dp,
  output logic dat_dn,
  output logic link_clk,
  output logic [7:0] hs_byte
);
  logic run;

  // Link clock stands low outside bursts; odd offset keeps it unrelated to clk
  initial begin
    {clk_dp, clk_dn, dat_dp, dat_dn} = 4'h f;
    link_clk = 1'b0;
    run = 1'b0;
    hs_byte = 8'h00;
    #13;
    forever begin
      #80;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic lp(input logic clk_ln, input logic [1:0] st);
    if (clk_ln) {clk_dp, clk_dn} = st;
    else {dat_dp, dat_dn} = st;
    #150;
  endtask : lp

  // good=0 skips LP-01 on the data lane so the receiver must refuse the entry
  task automatic burst(input logic [7:0] b[$], input logic good);
    lp(1'b1, 2'h3);
    lp(1'b1, 2'h1);
    {clk_dp, clk_dn} = 2'h0;
    #400;
    run = 1'b1;
    #400;
    lp(1'b0, 2'h3);
    if (good) lp(1'b0, 2'h1);
    {dat_dp, dat_dn} = 2'h0;
    #600;
    @(posedge link_clk);
    #1 hs_byte = 8'hb8;
    foreach (b[i]) begin
      @(posedge link_clk);
      #1 hs_byte = b[i];
    end
    @(posedge link_clk);
    #1 hs_byte = {8{~b[b.size()-1][7]}};
    @(posedge link_clk);
    #1 {dat_dp, dat_dn} = 2'h3;
    hs_byte = ~hs_byte;
    repeat (8) @(posedge link_clk);
    #100;
    run = 1'b0;
    {clk_dp, clk_dn} = 2'h3;
    #300;
  endtask : burst
endmodule : csrx_tx_model
